//--- hw/ces_top.sv
`default_nettype none
module ces_top
    import ces_pkg::*;
(
    // clock and reset
    input  wire logic          MCLK_IN,
    input  wire logic          RST_N_IN,
    // host register port
    input  wire ces_reg_req_t  REG_REQ_IN,
    output logic [7:0]         REG_RDATA_OUT,
    // protocol engine events
    input  wire ces_proto_ev_t PROTO_EV_IN,
    input  wire logic [1:0]    RX_ACCEPT_IN,
    input  wire logic [7:0]    IRQ_SET_IN,
    input  wire logic [7:0]    IRQ_COND_IN,
    // interrupt and state outputs
    output logic               INT_N_OUT,
    output logic [2:0]         IRQ_CODE_OUT,
    output ces_mode_t          ERR_MODE_OUT
);

    // registered state and its next value
    ces_state_t st;
    ces_state_t next_st;

    // decoded register selects
    ces_sel_t   wr_sel;
    ces_sel_t   rd_sel;

    // priority code from the encoder
    logic [2:0] code;

    // counter sums with a carry bit for saturation
    logic [8:0] tx_sum;
    logic [8:0] rx_sum;

    // inputs of the interrupt flag update
    logic [7:0] host_flag;
    logic [7:0] hw_set;
    logic [7:0] cond;

    // error-state bookkeeping
    logic [1:0] ovr_set;
    logic       busoff_now;
    logic       recovered;
    logic       err_event;
    logic [5:0] state_bits;

    // address decode shared by read and write paths
    function automatic ces_sel_t decode_reg(input logic [7:0] addr);
        ces_sel_t sel;
        sel = CES_SEL_NONE;
        if (addr == ADDR_STATUS) begin
            sel = CES_SEL_STATUS;
        end else if (addr == ADDR_TX_COUNT) begin
            sel = CES_SEL_TXC;
        end else if (addr == ADDR_RX_COUNT) begin
            sel = CES_SEL_RXC;
        end else if (addr == ADDR_IRQ_EN) begin
            sel = CES_SEL_EN;
        end else if (addr == ADDR_IRQ_FLAG) begin
            sel = CES_SEL_FLAG;
        end else if (addr == ADDR_ERR_FLAGS) begin
            sel = CES_SEL_ERRF;
        end
        return sel;
    endfunction : decode_reg

    // masked merge of host write data into a register
    function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] data, input logic [7:0] mask);
        return (old & ~mask) | (data & mask);
    endfunction : merge

    // warning, passive and bus-off bits from the next counters
    function automatic logic [5:0] state_flags(input logic [7:0] tx, input logic [7:0] rx, input logic off);
        logic [5:0] f;
        f                = 6'h00;
        f[EF_TX_WARN]    = tx >= WARN_LIMIT;
        f[EF_RX_WARN]    = rx >= WARN_LIMIT;
        f[EF_TX_PASSIVE] = tx >= PASSIVE_LIMIT;
        f[EF_RX_PASSIVE] = rx >= PASSIVE_LIMIT;
        f[EF_BUS_OFF]    = off;
        // combined warning, cleared only when both low
        f[EF_ANY_WARN]   = f[EF_TX_WARN] | f[EF_RX_WARN];
        return f;
    endfunction : state_flags

    // read mux, counters readable at any time
    function automatic logic [7:0] read_reg(input ces_sel_t sel, input ces_state_t s);
        logic [7:0] v;
        v = RESET_BYTE;
        if (sel == CES_SEL_STATUS) begin
            v = {4'h0, s.code, 1'b0};
        end else if (sel == CES_SEL_TXC) begin
            v = s.tx_count;
        end else if (sel == CES_SEL_RXC) begin
            v = s.rx_count;
        end else if (sel == CES_SEL_EN) begin
            v = s.irq_en;
        end else if (sel == CES_SEL_FLAG) begin
            v = s.irq_flag;
        end else if (sel == CES_SEL_ERRF) begin
            v = s.err_flags;
        end
        return v;
    endfunction : read_reg

    // priority code of current flags and enables
    ces_irq_encode u_encode (
        .flag_in   (st.irq_flag),
        .enable_in (st.irq_en),
        .code_out  (code)
    );

    // next-state logic of counters, flags, interrupts and read data
    always_comb begin
        next_st    = st;
        wr_sel     = REG_REQ_IN.wr ? decode_reg(REG_REQ_IN.addr) : CES_SEL_NONE;
        rd_sel     = decode_reg(REG_REQ_IN.addr);
        tx_sum     = {1'b0, st.tx_count};
        rx_sum     = {1'b0, st.rx_count};
        busoff_now = (st.mode == CES_BUS_OFF);
        recovered  = 1'b0;
        host_flag  = st.irq_flag;
        hw_set     = IRQ_SET_IN & HW_EVENT_MASK;
        cond       = IRQ_COND_IN;
        ovr_set    = 2'b00;
        err_event  = 1'b0;
        state_bits = 6'h00;

        // error counters while on the bus; frozen while bus-off
        if (!busoff_now) begin
            // transmit error adds 8, success subtracts 1
            if (PROTO_EV_IN.tx_err) begin
                tx_sum = {1'b0, st.tx_count} + TX_ERR_STEP;
            end else if (PROTO_EV_IN.tx_ok && st.tx_count != RESET_BYTE) begin
                tx_sum = {1'b0, st.tx_count - COUNT_UNIT};
            end

            if (tx_sum > {1'b0, COUNT_MAX}) begin
                next_st.tx_count = COUNT_MAX;
                busoff_now       = 1'b1;
            end else begin
                next_st.tx_count = tx_sum[7:0];
            end

            // receive errors add 1 or 8
            if (PROTO_EV_IN.rx_err_big) begin
                rx_sum = {1'b0, st.rx_count} + RX_ERR_STEP;
            end else if (PROTO_EV_IN.rx_err_small) begin
                rx_sum = {1'b0, st.rx_count} + RX_ERR_UNIT;
            end else if (PROTO_EV_IN.rx_ok && st.rx_count >= PASSIVE_LIMIT) begin
                rx_sum = {1'b0, RX_RESTORE};
            end else if (PROTO_EV_IN.rx_ok && st.rx_count != RESET_BYTE) begin
                rx_sum = {1'b0, st.rx_count - COUNT_UNIT};
            end
            // receive count saturates instead of wrapping
            next_st.rx_count = (rx_sum > {1'b0, COUNT_MAX}) ? COUNT_MAX : rx_sum[7:0];

            // recovery progress only counts while bus-off
            next_st.run  = RESET_RUN;
            next_st.seqs = RESET_BYTE;
        end else if (PROTO_EV_IN.bit_tick) begin
            // count runs of recessive bits
            // a dominant bit restarts the run, not the run count
            if (!PROTO_EV_IN.bus_recessive) begin
                next_st.run = RESET_RUN;
            end else if (st.run == RECESSIVE_RUN - 4'h1) begin
                next_st.run = RESET_RUN;
                if (st.seqs == RECOVERY_SEQS - 8'h01) begin
                    recovered = 1'b1;
                end else begin
                    next_st.seqs = st.seqs + 8'h01;
                end
            end else begin
                next_st.run = st.run + 4'h1;
            end
        end

        if (recovered) begin
            busoff_now       = 1'b0;
            next_st.tx_count = RESET_BYTE;
            next_st.rx_count = RESET_BYTE;
            next_st.run      = RESET_RUN;
            next_st.seqs     = RESET_BYTE;
        end

        if (busoff_now) begin
            next_st.mode = CES_BUS_OFF;
        end else if (next_st.tx_count >= PASSIVE_LIMIT || next_st.rx_count >= PASSIVE_LIMIT) begin
            // one counter at 128 or more
            next_st.mode = CES_ERR_PASSIVE;
        end else begin
            next_st.mode = CES_ERR_ACTIVE;
        end

        // state bits follow the next counters, so they agree with the mode
        state_bits = state_flags(next_st.tx_count, next_st.rx_count, busoff_now);
        next_st.err_flags[EF_BUS_OFF:EF_ANY_WARN] = state_bits;

        if (RX_ACCEPT_IN[0] && st.irq_flag[IRQ_RX0]) begin
            ovr_set[0] = 1'b1;
        end else if (RX_ACCEPT_IN[0]) begin
            hw_set[IRQ_RX0] = 1'b1;
        end
        if (RX_ACCEPT_IN[1] && st.irq_flag[IRQ_RX1]) begin
            ovr_set[1] = 1'b1;
        end else if (RX_ACCEPT_IN[1]) begin
            hw_set[IRQ_RX1] = 1'b1;
        end

        // host clears overflow bits, set wins
        // ones written under the mask are ignored; only clears land
        if (wr_sel == CES_SEL_ERRF) begin
            next_st.err_flags[EF_RX0_OVER] = st.err_flags[EF_RX0_OVER]
                & ~(REG_REQ_IN.mask[EF_RX0_OVER] & ~REG_REQ_IN.wdata[EF_RX0_OVER]);
            next_st.err_flags[EF_RX1_OVER] = st.err_flags[EF_RX1_OVER]
                & ~(REG_REQ_IN.mask[EF_RX1_OVER] & ~REG_REQ_IN.wdata[EF_RX1_OVER]);
        end
        next_st.err_flags[EF_RX0_OVER] = next_st.err_flags[EF_RX0_OVER] | ovr_set[0];
        next_st.err_flags[EF_RX1_OVER] = next_st.err_flags[EF_RX1_OVER] | ovr_set[1];

        // overflow or state change raises error flag
        err_event       = (|ovr_set) || (state_bits != st.err_flags[EF_BUS_OFF:EF_ANY_WARN]);
        hw_set[IRQ_ERR] = err_event;
        // error condition persists while an overflow bit is set
        cond[IRQ_ERR]   = st.err_flags[EF_RX0_OVER] | st.err_flags[EF_RX1_OVER];

        if (wr_sel == CES_SEL_EN) begin
            next_st.irq_en = merge(st.irq_en, REG_REQ_IN.wdata, REG_REQ_IN.mask);
        end

        // host writes may set any flag
        if (wr_sel == CES_SEL_FLAG) begin
            host_flag = merge(st.irq_flag, REG_REQ_IN.wdata, REG_REQ_IN.mask);
        end

        // hardware set wins over a host clear in the same cycle
        for (int i = 0; i < 8; i++) begin
            next_st.irq_flag[i] = host_flag[i] | (st.irq_flag[i] & cond[i]) | hw_set[i];
        end

        // pin and code lag the flags by one cycle, both from registers
        // pin low while enabled flag pending
        // released only when all pending cleared
        next_st.int_n = ~|(st.irq_flag & st.irq_en);
        next_st.code  = code;

        // read data stands until the next read strobe
        if (REG_REQ_IN.rd) begin
            next_st.rdata = read_reg(rd_sel, st);
        end
    end

    // state register
    always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            st.tx_count  <= RESET_BYTE;
            st.rx_count  <= RESET_BYTE;
            st.err_flags <= RESET_BYTE;
            st.irq_en    <= RESET_BYTE;
            st.irq_flag  <= RESET_BYTE;
            st.code      <= 3'h0;
            st.int_n     <= 1'b1;
            st.rdata     <= RESET_BYTE;
            st.run       <= RESET_RUN;
            st.seqs      <= RESET_BYTE;
            st.mode      <= CES_ERR_ACTIVE;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from state
    assign REG_RDATA_OUT = st.rdata;
    assign INT_N_OUT     = st.int_n;     // active low interrupt
    assign IRQ_CODE_OUT  = st.code;
    assign ERR_MODE_OUT  = st.mode;

endmodule : ces_top
`default_nettype wire

//--- pkg/ces_pkg.sv
`default_nettype none
package ces_pkg;

    // register addresses on the host register port
    localparam logic [7:0] ADDR_STATUS   = 8'h0e;
    localparam logic [7:0] ADDR_TX_COUNT  = 8'h1c;
    localparam logic [7:0] ADDR_RX_COUNT  = 8'h1d;
    localparam logic [7:0] ADDR_IRQ_EN    = 8'h2b;
    localparam logic [7:0] ADDR_IRQ_FLAG  = 8'h2c;
    localparam logic [7:0] ADDR_ERR_FLAGS = 8'h2d;

    // reset values
    localparam logic [7:0] RESET_BYTE    = 8'h00;
    localparam logic [3:0] RESET_RUN     = 4'h0;

    // counter limits and steps
    localparam logic [7:0] WARN_LIMIT    = 8'h60;
    localparam logic [7:0] PASSIVE_LIMIT = 8'h80;
    localparam logic [7:0] RX_RESTORE    = 8'h77;
    localparam logic [7:0] COUNT_MAX     = 8'hff;
    localparam logic [8:0] TX_ERR_STEP   = 9'h008;
    localparam logic [8:0] RX_ERR_STEP   = 9'h008;
    localparam logic [8:0] RX_ERR_UNIT   = 9'h001;
    localparam logic [7:0] COUNT_UNIT    = 8'h01;

    // bus-off recovery: 11 recessive bits, 128 times
    localparam logic [3:0] RECESSIVE_RUN = 4'hb;
    localparam logic [7:0] RECOVERY_SEQS = 8'h80;

    // error_state_flags bit positions
    localparam int EF_ANY_WARN   = 0;
    localparam int EF_RX_WARN    = 1;
    localparam int EF_TX_WARN    = 2;
    localparam int EF_RX_PASSIVE = 3;
    localparam int EF_TX_PASSIVE = 4;
    localparam int EF_BUS_OFF    = 5;
    localparam int EF_RX0_OVER   = 6;
    localparam int EF_RX1_OVER   = 7;

    // irq_enable_reg / irq_flag_reg bit positions
    localparam int IRQ_RX0  = 0;
    localparam int IRQ_RX1  = 1;
    localparam int IRQ_TX0  = 2;
    localparam int IRQ_TX1  = 3;
    localparam int IRQ_TX2  = 4;
    localparam int IRQ_ERR  = 5;
    localparam int IRQ_WAK  = 6;
    localparam int IRQ_MERR = 7;

    // sources set by IRQ_SET_IN; rx and err are set internally
    localparam logic [7:0] HW_EVENT_MASK = 8'hdc;
    // position of the priority code inside status_reg
    localparam int STATUS_CODE_POS = 1;

    typedef enum logic [1:0] {
        CES_ERR_ACTIVE  = 2'b00,
        CES_ERR_PASSIVE = 2'b01,
        CES_BUS_OFF     = 2'b10
    } ces_mode_t;

    typedef enum logic [2:0] {
        CES_SEL_NONE   = 3'b000,
        CES_SEL_STATUS = 3'b001,
        CES_SEL_TXC    = 3'b010,
        CES_SEL_RXC    = 3'b011,
        CES_SEL_EN     = 3'b100,
        CES_SEL_FLAG   = 3'b101,
        CES_SEL_ERRF   = 3'b110
    } ces_sel_t;

    // one host register access; mask 8'hff is a plain write
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] mask;
    } ces_reg_req_t;

    // fault-confinement events from the protocol engine
    typedef struct packed {
        logic tx_err;
        logic tx_ok;
        logic rx_err_small;
        logic rx_err_big;
        logic rx_ok;
        logic bit_tick;
        logic bus_recessive;
    } ces_proto_ev_t;

    typedef struct packed {
        logic [7:0] tx_count;
        logic [7:0] rx_count;
        logic [7:0] err_flags;
        logic [7:0] irq_en;
        logic [7:0] irq_flag;
        logic [2:0] code;
        logic       int_n;
        logic [7:0] rdata;
        logic [3:0] run;
        logic [7:0] seqs;
        ces_mode_t  mode;
    } ces_state_t;

endpackage : ces_pkg
`default_nettype wire

//--- hw/ces_irq_encode.sv
`default_nettype none
module ces_irq_encode
    import ces_pkg::*;
(
    // flags and enables
    input  wire logic [7:0] flag_in,
    input  wire logic [7:0] enable_in,
    // priority code
    output logic [2:0]      code_out
);

    // source bit for codes 1..7, highest priority first
    localparam int ORDER [7] = '{IRQ_ERR, IRQ_WAK, IRQ_TX0, IRQ_TX1, IRQ_TX2, IRQ_RX0, IRQ_RX1};

    logic [7:0] pending;

    assign pending = flag_in & enable_in;

    always_comb begin
        code_out = 3'h0;
        for (int k = 6; k >= 0; k--) begin
            if (pending[ORDER[k]]) begin
                code_out = 3'(k + 1);
            end
        end
    end

endmodule : ces_irq_encode
`default_nettype wire

//--- sim/ces_top_monitor.sv
`default_nettype none
module ces_top_monitor
    import ces_pkg::*;
(
    // clock and reset
    input wire logic          MCLK_IN,
    input wire logic          RST_N_IN,
    // inputs of the block
    input wire ces_reg_req_t  REG_REQ_IN,
    input wire ces_proto_ev_t PROTO_EV_IN,
    input wire logic [1:0]    RX_ACCEPT_IN,
    input wire logic [7:0]    IRQ_SET_IN,
    input wire logic [7:0]    IRQ_COND_IN,
    // outputs of the block
    input wire logic [7:0]    REG_RDATA_OUT,
    input wire logic          INT_N_OUT,
    input wire logic [2:0]    IRQ_CODE_OUT,
    input wire ces_mode_t     ERR_MODE_OUT
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (!RST_N_IN);
    // any stimulus able to move a flag
    logic ev;
    assign ev = REG_REQ_IN.wr | (|IRQ_SET_IN) | (|RX_ACCEPT_IN) | (|PROTO_EV_IN[6:1]);
    // interrupt pin and code
    chk_code_needs_pin: assert property (IRQ_CODE_OUT != 3'h0 |-> !INT_N_OUT)
        else $error("code pending while pin released");
    chk_pin_release_write: assert property ($rose(INT_N_OUT) |-> $past(REG_REQ_IN.wr, 2))
        else $error("pin released without host write");
    chk_pin_fall_cause: assert property ($fell(INT_N_OUT) |-> $past(ev, 2) || $past(ev, 3))
        else $error("pin fell without cause");
    chk_code_change_cause: assert property ($changed(IRQ_CODE_OUT)
        |-> $past(ev, 2) || $past(ev, 3) || $past(ev, 4))
        else $error("code changed without cause");
    // error mode
    chk_bus_off_entry: assert property (ERR_MODE_OUT == CES_BUS_OFF
        && $past(ERR_MODE_OUT) != CES_BUS_OFF |-> $past(PROTO_EV_IN.tx_err))
        else $error("bus-off entered without transmit error");
    chk_recover_active: assert property ($past(ERR_MODE_OUT) == CES_BUS_OFF
        && ERR_MODE_OUT != CES_BUS_OFF |-> ERR_MODE_OUT == CES_ERR_ACTIVE)
        else $error("bus-off left to a state other than active");
    chk_mode_event: assert property ($changed(ERR_MODE_OUT) |-> $past(|PROTO_EV_IN[6:1]))
        else $error("mode changed without counter event");
    // read port
    chk_rdata_holds: assert property (!$past(REG_REQ_IN.rd) |-> $stable(REG_RDATA_OUT))
        else $error("read data moved without read");
    chk_status_read: assert property (REG_REQ_IN.rd && REG_REQ_IN.addr == ADDR_STATUS
        |=> REG_RDATA_OUT == {4'h0, $past(IRQ_CODE_OUT), 1'b0})
        else $error("status read mismatch");
endmodule : ces_top_monitor
bind ces_top ces_top_monitor i_mon (.*);
`default_nettype wire

//--- sim/ces_host_model.sv
`default_nettype none
module ces_host_model
    import ces_pkg::*;
(
    // clock and read data
    input  wire logic [7:0]   rdata_in,
    input  wire logic         mclk_in,
    // register request
    output var ces_reg_req_t  req_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial req_out = '0;
    task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [7:0] m);
        @(negedge mclk_in) req_out = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v, mask: m};
        @(negedge mclk_in) req_out = '0;
    endtask : wr
    // read, data taken after the sampling edge
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(negedge mclk_in) req_out = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00, mask: 8'h00};
        @(negedge mclk_in) req_out = '0;
        v = rdata_in;
    endtask : rd
endmodule : ces_host_model
`default_nettype wire

//--- sim/can_error_state_and_irq_tb.sv
`default_nettype none
module can_error_state_and_irq_tb import ces_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int ORD [8] = '{IRQ_ERR, IRQ_WAK, IRQ_TX0, IRQ_TX1, IRQ_TX2, IRQ_RX0, IRQ_RX1, IRQ_MERR};
    localparam logic [7:0] ADRS [7] = '{ADDR_STATUS, ADDR_TX_COUNT, ADDR_RX_COUNT, ADDR_IRQ_EN, ADDR_IRQ_FLAG,
        ADDR_ERR_FLAGS, 8'h55};
    logic          clk = 1'b0;
    logic          rst_n = 1'b0;
    ces_reg_req_t  req;
    ces_proto_ev_t ev = '0;
    logic [1:0]    acc = 2'h0;
    logic [7:0]    set = 8'h00;
    logic [7:0]    cond = 8'h00;
    logic [7:0]    rdata, d, f, e;
    logic          int_n;
    logic [2:0]    code;
    ces_mode_t     mode;
    int            miscompares = 0;
    int            n_tests = 0;
    int            cycles = 0;
    integer        seed = 32'hca1a;
    ces_top i_dut (.MCLK_IN(clk), .RST_N_IN(rst_n), .REG_REQ_IN(req), .REG_RDATA_OUT(rdata),
        .PROTO_EV_IN(ev), .RX_ACCEPT_IN(acc), .IRQ_SET_IN(set), .IRQ_COND_IN(cond),
        .INT_N_OUT(int_n), .IRQ_CODE_OUT(code), .ERR_MODE_OUT(mode));
    ces_host_model i_host (.rdata_in(rdata), .mclk_in(clk), .req_out(req));
    // expected code of pending enabled sources
    function automatic logic [2:0] exp_code(input logic [7:0] p);
        for (int i = 0; i < 7; i++) if (p[ORD[i]]) return 3'(i + 1);
        return 3'h0;
    endfunction : exp_code
    function automatic logic [7:0] exp_flags(input logic [7:0] t, input logic [7:0] r, input logic bo);
        return {2'h0, bo, t >= PASSIVE_LIMIT, r >= PASSIVE_LIMIT, t >= WARN_LIMIT, r >= WARN_LIMIT,
            t >= WARN_LIMIT || r >= WARN_LIMIT};
    endfunction : exp_flags
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        i_host.rd(a, d);
        chk(d, exp);
    endtask : rchk
    task automatic pulse(input ces_proto_ev_t p, input int n);
        repeat (n) begin
            @(negedge clk) ev = p;
            @(negedge clk) ev = '0;
        end
    endtask : pulse
    task automatic end_of_test;
        if (miscompares == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : end_of_test
    // clock and timeout
    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            end_of_test();
        end
    end
    // main sequence
    initial begin
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        foreach (ADRS[i]) rchk(ADRS[i], 8'h00);
        i_host.wr(ADDR_TX_COUNT, 8'h5a, 8'hff);
        rchk(ADDR_TX_COUNT, 8'h00);
        for (int i = 1; i <= 31; i++) begin
            pulse(7'h40, 1);
            if (i inside {11, 12, 15, 16}) begin
                rchk(ADDR_TX_COUNT, 8'(i * 8));
                rchk(ADDR_ERR_FLAGS, exp_flags(8'(i * 8), 8'h00, 1'b0));
                chk(8'(mode), (i >= 16) ? 8'h01 : 8'h00);
            end
        end
        pulse(7'h40, 1);
        pulse(7'h20, 1);
        rchk(ADDR_TX_COUNT, 8'hff);
        rchk(ADDR_ERR_FLAGS, exp_flags(8'hff, 8'h00, 1'b1));
        chk(8'(mode), 8'h02);
        i_host.rd(ADDR_IRQ_FLAG, d);
        chk(d & 8'h20, 8'h20);
        pulse(7'h03, 5);
        pulse(7'h02, 1);
        pulse(7'h03, 128 * 11 - 1);
        chk(8'(mode), 8'h02);
        pulse(7'h03, 1);
        repeat (2) @(negedge clk);
        chk(8'(mode), 8'h00);
        rchk(ADDR_ERR_FLAGS, 8'h00);
        pulse(7'h08, 16);
        rchk(ADDR_ERR_FLAGS, exp_flags(8'h00, 8'h80, 1'b0));
        pulse(7'h04, 1);
        pulse(7'h10, 1);
        rchk(ADDR_RX_COUNT, 8'h78);
        for (int i = 0; i < 24; i++) begin
            e = (i == 0) ? 8'hff : $random(seed);
            f = (i == 0) ? 8'h80 : $random(seed);
            i_host.wr(ADDR_IRQ_EN, e, 8'hff);
            i_host.wr(ADDR_IRQ_FLAG, f, 8'hff);
            repeat (2) @(negedge clk);
            chk(8'(code), 8'(exp_code(f & e)));
            chk(8'(int_n), 8'(~|(f & e)));
        end
        e = 8'hff;
        f = 8'hff;
        i_host.wr(ADDR_IRQ_EN, e, 8'hff);
        i_host.wr(ADDR_IRQ_FLAG, f, 8'hff);
        foreach (ORD[k]) begin
            f[ORD[k]] = 1'b0;
            i_host.wr(ADDR_IRQ_FLAG, 8'h00, 8'(1 << ORD[k]));
            repeat (2) @(negedge clk);
            chk(8'(code), 8'(exp_code(f & e)));
            chk(8'(int_n), 8'((f & e) == 8'h00));
            rchk(ADDR_STATUS, {4'h0, exp_code(f & e), 1'b0});
        end
        @(negedge clk) {set, cond} = 16'h0404;
        @(negedge clk) set = 8'h00;
        i_host.wr(ADDR_IRQ_FLAG, 8'h00, 8'h04);
        chk(8'(int_n), 8'h00);
        rchk(ADDR_IRQ_FLAG, 8'h04);
        cond = 8'h00;
        i_host.wr(ADDR_IRQ_FLAG, 8'h00, 8'h04);
        rchk(ADDR_IRQ_FLAG, 8'h00);
        repeat (2) begin
            @(negedge clk) acc = 2'h1;
            @(negedge clk) acc = 2'h0;
        end
        rchk(ADDR_ERR_FLAGS, 8'h43);
        i_host.wr(ADDR_IRQ_FLAG, 8'h00, 8'h20);
        i_host.rd(ADDR_IRQ_FLAG, d);
        chk(d & 8'h20, 8'h20);
        i_host.wr(ADDR_ERR_FLAGS, 8'h00, 8'h40);
        rchk(ADDR_ERR_FLAGS, 8'h03);
        i_host.wr(ADDR_IRQ_FLAG, 8'h00, 8'h20);
        i_host.rd(ADDR_IRQ_FLAG, d);
        chk(d & 8'h20, 8'h00);
        end_of_test();
    end
endmodule : can_error_state_and_irq_tb
`default_nettype wire
